// ---- asbx_pkg.sv ----
/*
  asbx_pkg: constants for the add/shift/bit/branch execution block.
  Assumes a single 100 MHz core clock; no other package is needed.
*/
// Functional notes
// [RULE_01] add_accum_file sums acc and file f 0..127 and updates all flags.
// [RULE_02] for add and shift ops, dest 0 writes acc and dest 1 writes file f.
// [RULE_03] add_with_carry_file adds acc, file f and carry; updates all flags.
// [RULE_04] arith_shift_right: old bit 0 to carry, zero updated, nibble kept.
// [RULE_05] arith_shift_right keeps bit 7 equal to the original bit 7.
// [RULE_06] bit_clear_file clears bit b 0..7 of f only and changes no flag.
// [RULE_07] skip_if_bit_low: a low bit swaps the next op for an idle_slot.
// [RULE_08] skip_if_bit_high: high bit skips to an idle_slot; flags kept.
// [RULE_09] relative_jump sets pc to pc+1+k, k signed 9 bits; flags kept. Here the idle_slot that follows adds 1, leaving pc+2+k.
// [RULE_10] relative_jump takes two cycles, dropping the already fetched op.
// [RULE_11] an idle_slot only advances the program_counter; all else is kept.
package asbx_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BIT_W = 3;
  localparam int unsigned OFS_W = 9;
  localparam int unsigned PC_W = 15;
  localparam int unsigned OP_W = 3;
  localparam int unsigned MSB_POS = 7;
  localparam int unsigned NIB_W = 4;

  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

  // wishbone register byte addresses
  localparam logic [3:0] REG_INSTR = 4'h0;
  localparam logic [3:0] REG_ACC = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_PC = 4'hc;

  // instr register fields
  localparam int unsigned F_OP = 0;
  localparam int unsigned F_DEST = 3;
  localparam int unsigned F_BIT = 4;
  localparam int unsigned F_ADDR = 8;
  localparam int unsigned F_OFS = 16;

  // status register fields
  localparam int unsigned S_CARRY = 0;
  localparam int unsigned S_NIB = 1;
  localparam int unsigned S_ZERO = 2;
  localparam int unsigned S_IDLE = 3;

  typedef enum logic [OP_W-1:0] {
    OP_IDLE = 3'b000,
    OP_ADD = 3'b001,
    OP_ADDC = 3'b010,
    OP_ASR = 3'b011,
    OP_BCLR = 3'b100,
    OP_SKIP_LOW = 3'b101,
    OP_SKIP_HIGH = 3'b110,
    OP_JUMP = 3'b111
  } asbx_op_type;

endpackage

// ---- asbx_file_ram.sv ----
/*
  asbx_file_ram: the 128-entry file register array.
  Assumes one write port and one combinational read port on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module asbx_file_ram #(
  parameter int unsigned DEPTH = 128
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [asbx_pkg::ADDR_W-1:0] addr_i,
  input wire logic [asbx_pkg::DATA_W-1:0] wdata_i,
  output logic [asbx_pkg::DATA_W-1:0] rdata_o
);
  logic [asbx_pkg::DATA_W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[addr_i];
endmodule
`default_nettype wire

// ---- asbx_alu.sv ----
/*
  asbx_alu: combinational result and flag logic for the add/shift/bit ops.
  Assumes operands are stable for the whole execute cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module asbx_alu (
  input wire asbx_pkg::asbx_op_type op_i,
  input wire logic [asbx_pkg::DATA_W-1:0] acc_i,
  input wire logic [asbx_pkg::DATA_W-1:0] file_i,
  input wire logic [asbx_pkg::BIT_W-1:0] bit_i,
  input wire logic carry_i,
  input wire logic nib_i,
  output logic [asbx_pkg::DATA_W-1:0] result_o,
  output logic carry_o,
  output logic nib_o,
  output logic bit_val_o
);
  localparam int unsigned DW = asbx_pkg::DATA_W;
  localparam int unsigned NW = asbx_pkg::NIB_W;
  logic [DW:0] sum;
  logic [NW:0] nsum;
  logic cin;

  always_comb begin
    cin = (op_i == asbx_pkg::OP_ADDC) ? carry_i : 1'b0; // RULE_03
    sum = {1'b0, acc_i} + {1'b0, file_i} + {{DW{1'b0}}, cin}; // RULE_01
    nsum = {1'b0, acc_i[NW-1:0]} + {1'b0, file_i[NW-1:0]}
      + {{NW{1'b0}}, cin};
    result_o = file_i;
    carry_o = carry_i;
    nib_o = nib_i;
    unique case (op_i)
      asbx_pkg::OP_ADD, asbx_pkg::OP_ADDC: begin
        result_o = sum[DW-1:0]; // RULE_01
        carry_o = sum[DW];
        nib_o = nsum[NW];
      end
      asbx_pkg::OP_ASR: begin
        // RULE_05
        result_o = {file_i[asbx_pkg::MSB_POS], file_i[DW-1:1]};
        carry_o = file_i[0]; // RULE_04
      end
      asbx_pkg::OP_BCLR: begin
        result_o = file_i & ~(8'h01 << bit_i); // RULE_06
      end
      default: begin
        result_o = file_i;
      end
    endcase
    bit_val_o = file_i[bit_i];
  end
endmodule
`default_nettype wire

// ---- asbx_exec.sv ----
/*
  asbx_exec: top of the add/shift/bit/branch execution block.
  Software issues one instruction by writing the instr register over
  classic wishbone; the block executes it in that cycle and, for a taken
  skip or a jump, runs an idle_slot in the following cycle. Assumes a single
  clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module asbx_exec #(
  parameter int unsigned FILE_DEPTH = 128
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy_o
);
  localparam int unsigned DW = asbx_pkg::DATA_W;
  localparam int unsigned PW = asbx_pkg::PC_W;
  localparam int unsigned OW = asbx_pkg::OFS_W;

  logic ack_q;
  logic [DW-1:0] acc_q;
  logic carry_q;
  logic nib_q;
  logic zero_q;
  logic [PW-1:0] pc_q;
  logic idle_q;
  logic [31:0] rdata_q;

  logic req;
  logic issue;
  asbx_pkg::asbx_op_type op;
  logic dest;
  logic [asbx_pkg::BIT_W-1:0] bsel;
  logic [asbx_pkg::ADDR_W-1:0] faddr;
  logic [OW-1:0] ofs;
  logic [DW-1:0] fdata;
  logic [DW-1:0] res;
  logic alu_c;
  logic alu_n;
  logic bval;
  logic arith;
  logic fwe;
  logic skip;

  // a request is answered one cycle later; issue happens on the ack edge
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  // instructions wait while an idle_slot runs, so ack is held off then
  assign issue = req & wb_we_i & (wb_adr_i == asbx_pkg::REG_INSTR)
    & wb_sel_i[0] & ~idle_q;

  assign op = asbx_pkg::asbx_op_type'(wb_dat_i[asbx_pkg::F_OP +: 3]);
  assign dest = wb_dat_i[asbx_pkg::F_DEST];
  assign bsel = wb_dat_i[asbx_pkg::F_BIT +: 3];
  assign faddr = wb_dat_i[asbx_pkg::F_ADDR +: 7];
  assign ofs = wb_dat_i[asbx_pkg::F_OFS +: 9];

  asbx_file_ram #(
    .DEPTH(FILE_DEPTH)
  ) u_ram (
    .clk_i(clk_i),
    .we_i(fwe),
    .addr_i(faddr),
    .wdata_i(res),
    .rdata_o(fdata)
  );

  asbx_alu u_alu (
    .op_i(op),
    .acc_i(acc_q),
    .file_i(fdata),
    .bit_i(bsel),
    .carry_i(carry_q),
    .nib_i(nib_q),
    .result_o(res),
    .carry_o(alu_c),
    .nib_o(alu_n),
    .bit_val_o(bval)
  );

  assign arith = (op == asbx_pkg::OP_ADD) | (op == asbx_pkg::OP_ADDC)
    | (op == asbx_pkg::OP_ASR);
  // RULE_02 RULE_06
  assign fwe = issue & ((arith & dest) | (op == asbx_pkg::OP_BCLR));
  assign skip = issue & (((op == asbx_pkg::OP_SKIP_LOW) & ~bval) // RULE_07
    | ((op == asbx_pkg::OP_SKIP_HIGH) & bval) // RULE_08
    | (op == asbx_pkg::OP_JUMP)); // RULE_10

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~(wb_we_i & (wb_adr_i == asbx_pkg::REG_INSTR)
        & wb_sel_i[0] & idle_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= asbx_pkg::ACC_RESET;
    end else if (issue & arith & ~dest) begin
      acc_q <= res; // RULE_02
    end else if (req & wb_we_i & (wb_adr_i == asbx_pkg::REG_ACC)
        & wb_sel_i[0]) begin
      acc_q <= wb_dat_i[DW-1:0];
    end
  end

  // flags change only for add and shift or a status register write; bit ops, skips and jumps keep them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_q <= 1'b0;
      nib_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (issue & arith) begin
      carry_q <= alu_c; // RULE_01 RULE_03 RULE_04
      nib_q <= alu_n;
      zero_q <= (res == 8'h00);
    end else if (req & wb_we_i & (wb_adr_i == asbx_pkg::REG_STATUS)
        & wb_sel_i[0]) begin
      carry_q <= wb_dat_i[asbx_pkg::S_CARRY];
      nib_q <= wb_dat_i[asbx_pkg::S_NIB];
      zero_q <= wb_dat_i[asbx_pkg::S_ZERO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= asbx_pkg::PC_RESET;
    end else if (issue & (op == asbx_pkg::OP_JUMP)) begin
      // pc_q still holds the jump's own address, so this is pc+1+k
      pc_q <= pc_q + PW'(1) + {{(PW-OW){ofs[OW-1]}}, ofs}; // RULE_09
    end else if (issue | idle_q) begin
      pc_q <= pc_q + PW'(1); // RULE_11
    end else if (req & wb_we_i & (wb_adr_i == asbx_pkg::REG_PC)
        & (&wb_sel_i[1:0])) begin
      pc_q <= wb_dat_i[PW-1:0];
    end
  end

  // the idle_slot lasts one cycle and touches nothing but the pc
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= skip; // RULE_07 RULE_08 RULE_10 RULE_11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (req & ~wb_we_i) begin
      unique case (wb_adr_i)
        asbx_pkg::REG_ACC: rdata_q <= {24'h00_0000, acc_q};
        asbx_pkg::REG_STATUS: rdata_q <= {28'h000_0000, idle_q, zero_q,
          nib_q, carry_q};
        asbx_pkg::REG_PC: rdata_q <= {17'h0_0000, pc_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign busy_o = idle_q;
endmodule
`default_nettype wire

// ---- asbx_exec_checker.sv ----
/* asbx_exec_checker: port assertions for asbx_exec.
   assumes a classic wishbone master that waits for ack. */
`timescale 1ns/1ps
`default_nettype none
module asbx_exec_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // instruction write seen at the edge where the master takes ack
  // a write with byte 0 disabled is acked but never executed
  wire ins_ack = wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i == asbx_pkg::REG_INSTR;
  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  AST_ACK_CAUSE: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  AST_ANSWER: assert property (
    $rose(wb_cyc_i && wb_stb_i) |-> ##[1:2] wb_ack_o)
    else $error("no answer");
  AST_IDLE_ONE: assert property (
    busy_o |=> !busy_o) else $error("idle slot too long");
  AST_IDLE_CAUSE: assert property (
    $rose(busy_o) |-> ins_ack && wb_dat_i[2:0] >= 3'h5)
    else $error("idle slot without skip or jump");
  AST_JUMP_IDLE: assert property (
    ins_ack && wb_dat_i[2:0] == 3'h7 |-> busy_o)
    else $error("jump without idle slot");
  AST_PLAIN_NO_IDLE: assert property (
    ins_ack && wb_dat_i[2:0] < 3'h5 |-> !busy_o)
    else $error("idle slot after plain op");
  AST_INSTR_READ_ZERO: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o == '0)
    else $error("instr register read not zero");
  cover property (ins_ack && wb_dat_i[2:0] == 3'h7);
  cover property (busy_o);
  cover property (wb_ack_o && !wb_we_i);
endmodule
bind asbx_exec asbx_exec_checker u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .busy_o(busy_o)
);
`default_nettype wire

// ---- tb_add_shift_bit_branch_exec.sv ----
/* tb_add_shift_bit_branch_exec: directed bench for asbx_exec.
   assumes the block's register map and a registered one-cycle ack. */
`timescale 1ns/1ps
`default_nettype none
module tb_add_shift_bit_branch_exec;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = '0, wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, d;
  logic wb_ack_o, busy_o, bs;
  int n_errors = 0, checks = 0;
  always #5 clk_i = ~clk_i;
  asbx_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busy_o(busy_o));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] v);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= v;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    bs = busy_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic ins(input logic [2:0] op, input logic ds,
    input logic [2:0] b, input logic [6:0] f, input logic [8:0] k);
    bus(1, 4'h0, {7'h00, k, 1'b0, f, 1'b0, b, ds, op});
  endtask
  // file ram powers up unknown, so clear every bit before loading
  task automatic setf(input logic [6:0] f, input logic [7:0] v);
    for (int b = 0; b < 8; b++) ins(3'h4, 0, b[2:0], f, 9'h000);
    bus(1, 4'h4, {24'h00_0000, v});
    ins(3'h1, 1, 3'h0, f, 9'h000);
  endtask
  task automatic getf(input logic [6:0] f);
    bus(1, 4'h4, '0);
    ins(3'h1, 0, 3'h0, f, 9'h000);
    bus(0, 4'h4, '0);
  endtask
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  initial begin
    logic t;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 4'h8, '0); chk("status", d, '0);
    bus(0, 4'hc, '0); chk("pc", d, '0);
    bus(1, 4'h2, 32'h0000_00ff); bus(0, 4'h2, '0); chk("unmapped", d, '0);
    setf(7'h01, 8'h8f);
    bus(1, 4'h4, 32'h0000_0071);
    ins(3'h1, 0, 3'h0, 7'h01, 9'h000);
    bus(0, 4'h4, '0); chk("add acc", d, '0);
    bus(0, 4'h8, '0); chk("add flags", d, 32'h0000_0007);
    bus(1, 4'h4, 32'h0000_0010);
    ins(3'h2, 1, 3'h0, 7'h01, 9'h000);
    bus(0, 4'h4, '0); chk("addc acc", d, 32'h0000_0010);
    bus(0, 4'h8, '0); chk("addc flags", d, 32'h0000_0002);
    getf(7'h01); chk("addc file", d, 32'h0000_00a0);
    setf(7'h02, 8'h81);
    bus(1, 4'h8, 32'h0000_0002);
    ins(3'h3, 0, 3'h0, 7'h02, 9'h000);
    bus(0, 4'h4, '0); chk("asr acc", d, 32'h0000_00c0);
    bus(0, 4'h8, '0); chk("asr flags", d, 32'h0000_0003);
    setf(7'h03, 8'h01);
    bus(1, 4'h8, '0);
    ins(3'h3, 1, 3'h0, 7'h03, 9'h000);
    bus(0, 4'h8, '0); chk("asr zero", d, 32'h0000_0005);
    getf(7'h03); chk("asr file", d, '0);
    setf(7'h04, 8'hff);
    bus(1, 4'h8, 32'h0000_0005);
    ins(3'h4, 0, 3'h7, 7'h04, 9'h000);
    ins(3'h4, 0, 3'h0, 7'h04, 9'h000);
    bus(0, 4'h8, '0); chk("bclr flags", d, 32'h0000_0005);
    getf(7'h04); chk("bclr file", d, 32'h0000_007e);
    bus(0, 4'h0, '0);
    chk("instr read", d, '0);
    // file 4 holds bit0 low and bit1 high
    for (int i = 0; i < 4; i++) begin
      t = (i == 0 || i == 3);
      bus(1, 4'hc, 32'h0000_0010);
      bus(1, 4'h8, 32'h0000_0005);
      ins(i < 2 ? 3'h5 : 3'h6, 0, {2'b00, i[0]}, 7'h04, 9'h000);
      chk("skip busy", bs, t);
      bus(0, 4'hc, '0);
      chk("skip pc", d, 32'h0000_0011 + t);
      bus(0, 4'h8, '0); chk("skip flags", d, 32'h0000_0005);
    end
    for (int j = 0; j < 2; j++) begin
      bus(1, 4'hc, 32'h0000_0200);
      ins(3'h7, 0, 3'h0, 7'h00, j ? 9'h0ff : 9'h100);
      chk("jump busy", bs, 1'b1);
      bus(0, 4'hc, '0);
      chk("jump pc", d, j ? 32'h0000_0301 : 32'h0000_0102);
      bus(0, 4'h8, '0); chk("jump flags", d, 32'h0000_0005);
    end
    // a plain idle op: pc steps by one, no idle_slot, nothing else moves
    bus(1, 4'hc, 32'h0000_0020);
    ins(3'h0, 0, 3'h0, 7'h00, 9'h000);
    chk("idle busy", bs, 1'b0);
    bus(0, 4'hc, '0);
    chk("idle pc", d, 32'h0000_0021);
    bus(0, 4'h8, '0);
    chk("idle flags", d, 32'h0000_0005);
    bus(0, 4'h4, '0);
    chk("idle acc", d, 32'h0000_007e);
    print_verdict();
  end
endmodule
`default_nettype wire
